// ==== design/tsc_pkg.sv ====
// ==========================================================
// Shared constants, types and helpers
package tsc_pkg;

    // ======================================================
    // Instruction field positions
    localparam int POS_OP = 26;
    localparam int POS_RS = 21;
    localparam int POS_RT = 16;
    localparam int POS_RD = 11;
    localparam int POS_FN = 0;
    localparam int POS_IMM = 0;
    localparam int POS_COFUN = 0;
    localparam int CO_BIT = 25;
    localparam int BR_SENSE_BIT = 16;
    localparam int NUM_UNITS = 4;
    localparam int NUM_REGS = 32;

    // ======================================================
    // Primary opcodes and opcode groups (top four bits)
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_REG_IMM = 6'h01;
    localparam logic [3:0] OPG_COP = 4'h4;
    localparam logic [3:0] OPG_LWC = 4'hc;
    localparam logic [3:0] OPG_SWC = 4'he;
    localparam logic [1:0] UNIT_SYSCTL = 2'h0;

    // Function codes under the special opcode
    localparam logic [5:0] FN_SYSCALL = 6'h0c;
    localparam logic [5:0] FN_BREAK = 6'h0d;
    localparam logic [5:0] FN_SYNC = 6'h0f;
    localparam logic [5:0] FN_TRAP_GE_S = 6'h30;
    localparam logic [5:0] FN_TRAP_GE_U = 6'h31;
    localparam logic [5:0] FN_TRAP_LT_S = 6'h32;
    localparam logic [5:0] FN_TRAP_LT_U = 6'h33;
    localparam logic [5:0] FN_TRAP_EQ = 6'h34;
    localparam logic [5:0] FN_TRAP_NE = 6'h36;

    // Sub-operations under the register-immediate opcode
    localparam logic [4:0] RI_TRAP_GE_S = 5'h08;
    localparam logic [4:0] RI_TRAP_GE_U = 5'h09;
    localparam logic [4:0] RI_TRAP_LT_S = 5'h0a;
    localparam logic [4:0] RI_TRAP_LT_U = 5'h0b;
    localparam logic [4:0] RI_TRAP_EQ = 5'h0c;
    localparam logic [4:0] RI_TRAP_NE = 5'h0e;

    // Sub-operations in the rs field of coprocessor opcodes
    localparam logic [4:0] CS_MF = 5'h00;
    localparam logic [4:0] CS_CF = 5'h02;
    localparam logic [4:0] CS_MT = 5'h04;
    localparam logic [4:0] CS_CT = 5'h06;
    localparam logic [4:0] CS_BC = 5'h08;

    // Distance from a branch to its delay slot
    localparam logic [63:0] DELAY_SLOT_STEP = 64'h4;

    // ======================================================
    // Types
    typedef enum logic [1:0] {
        EXC_NONE, EXC_SYSCALL, EXC_BREAK, EXC_TRAP
    } tsc_exc_t;

    typedef enum logic [2:0] {
        CK_WR_GPR, CK_RD_GPR, CK_WR_CTL, CK_RD_CTL, CK_OPER
    } tsc_cop_kind_t;

    typedef enum logic [2:0] {
        TC_GE_S, TC_GE_U, TC_LT_S, TC_LT_U, TC_EQ, TC_NE
    } tsc_tcond_t;

    // ======================================================
    // Helpers
    function automatic logic [63:0] tsc_sext16(input logic [15:0] v);
        return {{48{v[15]}}, v};
    endfunction : tsc_sext16

    function automatic logic [63:0] tsc_br_target(
        input logic [63:0] pc, input logic [15:0] off);
        logic [31:0] off32;
        off32 = {{14{off[15]}}, off, 2'b00};
        return pc + DELAY_SLOT_STEP + {{32{off32[31]}}, off32};
    endfunction : tsc_br_target

endpackage : tsc_pkg

// ==== design/tsc_cop_if.sv ====
`timescale 1ns/10ps
// ==========================================================
// CPU to coprocessor link
interface tsc_cop_if;
    import tsc_pkg::*;
    // Request from the CPU end, one-cycle pulse
    logic req_valid;
    tsc_cop_kind_t req_kind;
    logic [1:0] req_unit;
    logic [4:0] req_idx;
    logic [31:0] req_wdata;
    logic [24:0] req_fun;
    // Read answer from the coprocessor end
    logic rsp_valid;
    logic [31:0] rsp_data;
    // Condition signal of each unit
    logic [NUM_UNITS-1:0] cond;

    modport cpu_end (
        output req_valid, req_kind, req_unit, req_idx, req_wdata, req_fun,
        input rsp_valid, rsp_data, cond
    );
    modport cop_end (
        input req_valid, req_kind, req_unit, req_idx, req_wdata, req_fun,
        output rsp_valid, rsp_data, cond
    );
endinterface : tsc_cop_if

// ==== design/tsc_trap_cmp.sv ====
`timescale 1ns/10ps
// ==========================================================
// Trap condition comparator
module tsc_trap_cmp
    import tsc_pkg::*;
(
    // Operands and condition
    input wire logic [63:0] op_a,
    input wire logic [63:0] op_b,
    input wire tsc_tcond_t tcond,
    // Result
    output logic hit
);

    // Signed, unsigned and equality compares
    always_comb begin
        case (tcond)
            TC_GE_S: hit = !($signed(op_a) < $signed(op_b));
            TC_LT_S: hit = $signed(op_a) < $signed(op_b);
            TC_GE_U: hit = !(op_a < op_b);
            TC_LT_U: hit = op_a < op_b;
            TC_EQ: hit = op_a == op_b;
            TC_NE: hit = op_a != op_b;
            default: hit = 1'b0;
        endcase
    end

endmodule : tsc_trap_cmp

// ==== design/tsc_cop_end.sv ====
`timescale 1ns/10ps
// ==========================================================
// Coprocessor end: register files, condition and operations
module tsc_cop_end
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to the CPU
    tsc_cop_if.cop_end cop,
    // Condition signals from the coprocessor datapaths
    input wire logic [NUM_UNITS-1:0] cond_in,
    // Operation issued to a coprocessor datapath
    output logic op_valid,
    output logic [1:0] op_unit,
    output logic [24:0] op_fun
);

    logic [31:0] gpr_mem [0:NUM_UNITS*NUM_REGS-1];
    logic [31:0] ctl_mem [0:NUM_UNITS*NUM_REGS-1];
    logic [6:0] sel;
    logic rsp_valid_ff;
    logic [31:0] rsp_data_ff;
    logic [NUM_UNITS-1:0] cond_ff;
    logic op_valid_ff;
    logic [1:0] op_unit_ff;
    logic [24:0] op_fun_ff;

    // Register select from unit and index
    assign sel = {cop.req_unit, cop.req_idx};

    // ======================================================
    // Register file writes
    always_ff @(posedge clk) begin
        if (cop.req_valid && cop.req_kind == CK_WR_GPR) begin
            gpr_mem[sel] <= cop.req_wdata;
        end
        if (cop.req_valid && cop.req_kind == CK_WR_CTL) begin
            ctl_mem[sel] <= cop.req_wdata;
        end
    end

    // Read answers, one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 32'h0;
        end else begin
            rsp_valid_ff <= 1'b0;
            if (cop.req_valid && cop.req_kind == CK_RD_GPR) begin
                rsp_valid_ff <= 1'b1;
                rsp_data_ff <= gpr_mem[sel];
            end else if (cop.req_valid && cop.req_kind == CK_RD_CTL) begin
                rsp_valid_ff <= 1'b1;
                rsp_data_ff <= ctl_mem[sel];
            end
        end
    end

    // Condition signals toward the CPU
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_ff <= '0;
        end else begin
            cond_ff <= cond_in;
        end
    end

    // Operation pass-through; no answer to the CPU
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_valid_ff <= 1'b0;
            op_unit_ff <= 2'h0;
            op_fun_ff <= 25'h0;
        end else begin
            op_valid_ff <= cop.req_valid && cop.req_kind == CK_OPER;
            if (cop.req_valid && cop.req_kind == CK_OPER) begin
                op_unit_ff <= cop.req_unit;
                op_fun_ff <= cop.req_fun;
            end
        end
    end

    // Outputs
    assign cop.rsp_valid = rsp_valid_ff;
    assign cop.rsp_data = rsp_data_ff;
    assign cop.cond = cond_ff;
    assign op_valid = op_valid_ff;
    assign op_unit = op_unit_ff;
    assign op_fun = op_fun_ff;

endmodule : tsc_cop_end

// ==== design/tsc_cpu_end.sv ====
`timescale 1ns/10ps
// ==========================================================
// CPU end: executes traps, barrier and coprocessor work
module tsc_cpu_end
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] instr_pc,
    input wire logic [63:0] rs_val,
    input wire logic [63:0] rt_val,
    output logic instr_ready,
    // Pipeline load/store state
    input wire logic lsu_idle,
    // Exceptions
    output logic exc_valid,
    output tsc_exc_t exc_kind,
    output logic [63:0] exc_pc,
    // CPU register write-back
    output logic wb_valid,
    output logic [4:0] wb_reg,
    output logic [63:0] wb_data,
    // Fetch redirect
    output logic redirect_valid,
    output logic [63:0] redirect_pc,
    // Memory port
    output logic mem_req,
    output logic mem_we,
    output logic [63:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // Coprocessor link
    tsc_cop_if.cpu_end cop
);

    typedef enum logic [2:0] {
        S_IDLE, S_SYNC, S_LD_MEM, S_ST_COP, S_ST_MEM, S_MV_COP
    } tsc_state_t;

    tsc_state_t state_ff, nxt_state;
    logic ready_ff;
    logic [5:0] op, fn;
    logic [4:0] rsf, rtf, rdf;
    logic [15:0] imm;
    logic [1:0] unit;
    logic cop_ok, is_cop, is_lw, is_sw, is_co, is_mf, is_cf, is_mt, is_ct;
    logic is_bc, is_sys, is_brk, is_sync, tr_known, is_trap, hit, accept;
    tsc_tcond_t tcond;
    logic [63:0] tb, ea;
    logic exc_valid_ff, wb_valid_ff, redir_ff, redir_pend_ff;
    tsc_exc_t exc_kind_ff;
    logic [63:0] exc_pc_ff, wb_data_ff, redir_pc_ff, pend_pc_ff;
    logic [4:0] wb_reg_ff, dest_ff, cidx_ff;
    logic [1:0] unit_ff;
    logic mem_req_ff, mem_we_ff;
    logic [63:0] mem_addr_ff;
    logic [31:0] mem_wdata_ff;
    logic creq_ff;
    tsc_cop_kind_t ckind_ff;
    logic [1:0] cunit_ff;
    logic [4:0] creg_ff;
    logic [31:0] cwdata_ff;
    logic [24:0] cfun_ff;

    // ======================================================
    // Decode
    always_comb begin
        op = instr[POS_OP +: 6];
        fn = instr[POS_FN +: 6];
        rsf = instr[POS_RS +: 5];
        rtf = instr[POS_RT +: 5];
        rdf = instr[POS_RD +: 5];
        imm = instr[POS_IMM +: 16];
        unit = op[1:0];
        cop_ok = unit != UNIT_SYSCTL;
        is_sys = op == OP_SPECIAL && fn == FN_SYSCALL;
        is_brk = op == OP_SPECIAL && fn == FN_BREAK;
        is_sync = op == OP_SPECIAL && fn == FN_SYNC;
        is_lw = op[5:2] == OPG_LWC && cop_ok;
        is_sw = op[5:2] == OPG_SWC && cop_ok;
        is_cop = op[5:2] == OPG_COP && cop_ok;
        is_co = is_cop && instr[CO_BIT];
        is_mf = is_cop && !instr[CO_BIT] && rsf == CS_MF;
        is_cf = is_cop && !instr[CO_BIT] && rsf == CS_CF;
        is_mt = is_cop && !instr[CO_BIT] && rsf == CS_MT;
        is_ct = is_cop && !instr[CO_BIT] && rsf == CS_CT;
        is_bc = is_cop && !instr[CO_BIT] && rsf == CS_BC;
        ea = rs_val + tsc_sext16(imm);
    end

    // Trap selection and second operand
    always_comb begin
        tcond = TC_EQ;
        tb = rt_val;
        tr_known = 1'b1;
        if (op == OP_SPECIAL) begin
            case (fn)
                FN_TRAP_GE_S: tcond = TC_GE_S;
                FN_TRAP_LT_S: tcond = TC_LT_S;
                FN_TRAP_GE_U: tcond = TC_GE_U;
                FN_TRAP_LT_U: tcond = TC_LT_U;
                FN_TRAP_EQ: tcond = TC_EQ;
                FN_TRAP_NE: tcond = TC_NE;
                default: tr_known = 1'b0;
            endcase
        end else if (op == OP_REG_IMM) begin
            tb = tsc_sext16(imm);
            case (rtf)
                RI_TRAP_GE_S: tcond = TC_GE_S;
                RI_TRAP_LT_S: tcond = TC_LT_S;
                RI_TRAP_GE_U: tcond = TC_GE_U;
                RI_TRAP_LT_U: tcond = TC_LT_U;
                RI_TRAP_EQ: tcond = TC_EQ;
                RI_TRAP_NE: tcond = TC_NE;
                default: tr_known = 1'b0;
            endcase
            if (rtf == RI_TRAP_GE_U || rtf == RI_TRAP_LT_U) begin
                tb = {48'h0, imm};
            end
        end else begin
            tr_known = 1'b0;
        end
        is_trap = tr_known;
    end

    tsc_trap_cmp u_cmp (
        .op_a(rs_val),
        .op_b(tb),
        .tcond(tcond),
        .hit(hit)
    );

    assign accept = instr_valid && ready_ff;

    // ======================================================
    // Sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (accept && is_sync && !lsu_idle) begin
                    nxt_state = S_SYNC;
                end else if (accept && is_lw) begin
                    nxt_state = S_LD_MEM;
                end else if (accept && is_sw) begin
                    nxt_state = S_ST_COP;
                end else if (accept && (is_mf || is_cf)) begin
                    nxt_state = S_MV_COP;
                end
            end
            S_SYNC: if (lsu_idle) nxt_state = S_IDLE;
            S_LD_MEM: if (mem_ack) nxt_state = S_IDLE;
            S_ST_COP: if (cop.rsp_valid) nxt_state = S_ST_MEM;
            S_ST_MEM: if (mem_ack) nxt_state = S_IDLE;
            S_MV_COP: if (cop.rsp_valid) nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    // State and issue ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ready_ff <= nxt_state == S_IDLE;
        end
    end

    // Captured operands of a multi-cycle instruction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_ff <= 2'h0;
            cidx_ff <= 5'h0;
            dest_ff <= 5'h0;
        end else if (accept) begin
            unit_ff <= unit;
            cidx_ff <= (is_lw || is_sw) ? rtf : rdf;
            dest_ff <= rtf;
        end
    end

    // ======================================================
    // Exceptions
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_valid_ff <= 1'b0;
            exc_kind_ff <= EXC_NONE;
            exc_pc_ff <= 64'h0;
        end else begin
            exc_valid_ff <= accept && (is_sys || is_brk || (is_trap && hit));
            if (accept && is_sys) begin
                exc_kind_ff <= EXC_SYSCALL;
                exc_pc_ff <= instr_pc;
            end else if (accept && is_brk) begin
                exc_kind_ff <= EXC_BREAK;
                exc_pc_ff <= instr_pc;
            end else if (accept && is_trap && hit) begin
                exc_kind_ff <= EXC_TRAP;
                exc_pc_ff <= instr_pc;
            end
        end
    end

    // Memory requests, held until acknowledged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_addr_ff <= 64'h0;
            mem_wdata_ff <= 32'h0;
        end else if (accept && (is_lw || is_sw)) begin
            mem_addr_ff <= ea;
            mem_req_ff <= is_lw;
            mem_we_ff <= 1'b0;
        end else if (state_ff == S_ST_COP && cop.rsp_valid) begin
            mem_req_ff <= 1'b1;
            mem_we_ff <= 1'b1;
            mem_wdata_ff <= cop.rsp_data;
        end else if (mem_ack) begin
            mem_req_ff <= 1'b0;
        end
    end

    // Coprocessor requests, one-cycle pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            creq_ff <= 1'b0;
            ckind_ff <= CK_OPER;
            cunit_ff <= 2'h0;
            creg_ff <= 5'h0;
            cwdata_ff <= 32'h0;
            cfun_ff <= 25'h0;
        end else begin
            creq_ff <= 1'b0;
            if (state_ff == S_LD_MEM && mem_ack) begin
                creq_ff <= 1'b1;
                ckind_ff <= CK_WR_GPR;
                cunit_ff <= unit_ff;
                creg_ff <= cidx_ff;
                cwdata_ff <= mem_rdata;
            end else if (accept && (is_mt || is_ct || is_co || is_sw
                         || is_mf || is_cf)) begin
                creq_ff <= 1'b1;
                cunit_ff <= unit;
                creg_ff <= is_sw ? rtf : rdf;
                cwdata_ff <= rt_val[31:0];
                cfun_ff <= instr[POS_COFUN +: 25];
                if (is_mt) ckind_ff <= CK_WR_GPR;
                else if (is_ct) ckind_ff <= CK_WR_CTL;
                else if (is_co) ckind_ff <= CK_OPER;
                else if (is_cf) ckind_ff <= CK_RD_CTL;
                else ckind_ff <= CK_RD_GPR;
            end
        end
    end

    // CPU register write-back of coprocessor reads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_valid_ff <= 1'b0;
            wb_reg_ff <= 5'h0;
            wb_data_ff <= 64'h0;
        end else begin
            wb_valid_ff <= state_ff == S_MV_COP && cop.rsp_valid;
            if (state_ff == S_MV_COP && cop.rsp_valid) begin
                wb_reg_ff <= dest_ff;
                wb_data_ff <= {{32{cop.rsp_data[31]}}, cop.rsp_data};
            end
        end
    end

    // Condition branches: redirect once the delay slot is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            redir_ff <= 1'b0;
            redir_pend_ff <= 1'b0;
            redir_pc_ff <= 64'h0;
            pend_pc_ff <= 64'h0;
        end else begin
            redir_ff <= 1'b0;
            if (accept && redir_pend_ff) begin
                redir_ff <= 1'b1;
                redir_pc_ff <= pend_pc_ff;
                redir_pend_ff <= 1'b0;
            end else if (accept && is_bc
                         && cop.cond[unit] == instr[BR_SENSE_BIT]) begin
                redir_pend_ff <= 1'b1;
                pend_pc_ff <= tsc_br_target(instr_pc, imm);
            end
        end
    end

    // Outputs
    assign instr_ready = ready_ff;
    assign exc_valid = exc_valid_ff;
    assign exc_kind = exc_kind_ff;
    assign exc_pc = exc_pc_ff;
    assign wb_valid = wb_valid_ff;
    assign wb_reg = wb_reg_ff;
    assign wb_data = wb_data_ff;
    assign redirect_valid = redir_ff;
    assign redirect_pc = redir_pc_ff;
    assign mem_req = mem_req_ff;
    assign mem_we = mem_we_ff;
    assign mem_addr = mem_addr_ff;
    assign mem_wdata = mem_wdata_ff;
    assign cop.req_valid = creq_ff;
    assign cop.req_kind = ckind_ff;
    assign cop.req_unit = cunit_ff;
    assign cop.req_idx = creg_ff;
    assign cop.req_wdata = cwdata_ff;
    assign cop.req_fun = cfun_ff;

endmodule : tsc_cpu_end

// ==== dv/tsc_link_chk_asserts.sv ====
`timescale 1ns/10ps
// ==========================================================
// Link checks
module tsc_link_chk
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link signals
    input wire logic req_valid,
    input wire tsc_cop_kind_t req_kind,
    input wire logic [1:0] req_unit,
    input wire logic [4:0] req_idx,
    input wire logic [31:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Request classes
    wire rd = req_valid && req_kind inside {CK_RD_GPR, CK_RD_CTL};
    wire wr = req_valid && req_kind inside {CK_WR_GPR, CK_WR_CTL};
    // Write then read of one place
    sequence s_echo(w, r);
        req_valid && req_kind == w ##1 req_valid && req_kind == r
            && req_idx == $past(req_idx) && req_unit == $past(req_unit);
    endsequence
    a_rd_answer: assert property (rd |=> rsp_valid)
        else $error("read not answered");
    a_rsp_cause: assert property (rsp_valid |-> $past(rd))
        else $error("answer without read");
    a_rsp_single: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer too long");
    a_rd_alone: assert property (rd |=> !req_valid)
        else $error("request during read");
    a_wr_silent: assert property (wr |=> !rsp_valid)
        else $error("answer to write");
    a_op_silent: assert property (req_valid && req_kind == CK_OPER
        |=> !rsp_valid) else $error("answer to operation");
    a_gpr_echo: assert property (s_echo(CK_WR_GPR, CK_RD_GPR) |=>
        rsp_data == $past(req_wdata, 2)) else $error("register lost");
    a_ctl_echo: assert property (s_echo(CK_WR_CTL, CK_RD_CTL) |=>
        rsp_data == $past(req_wdata, 2)) else $error("control lost");
endmodule : tsc_link_chk

// ==== dv/trap_sync_coproc_exec_tb.sv ====
`timescale 1ns/10ps
// ==========================================================
// Bench: CPU end and coprocessor end joined by the link
module trap_sync_coproc_exec_tb;
    import tsc_pkg::*;
    localparam logic [31:0] MW = 32'h8765_4321;
    localparam logic [63:0] N = 64'hffff_ffff_ffff_ffff;
    logic clk = 0, rst_n = 0, iv = 0, lsu_idle = 1, mem_ack = 0;
    logic [31:0] instr = 0, mwd, mwd_l;
    logic [63:0] pc = 0, rs = 0, rt = 0, epc, wd, rpc, ma, ma_l;
    logic [3:0] cin = 0;
    logic ir, ev, wv, rv, mreq, mwe, we_l, ov;
    logic [4:0] wreg;
    logic [1:0] ou;
    logic [24:0] fn;
    tsc_exc_t ek;
    int error_cnt = 0, cmp_count = 0, cyc = 0, en = 0, wn = 0, rn = 0;
    int mc = 0, on = 0;
    tsc_cop_if link();
    // ======================================================
    // Units under test and checker
    tsc_cpu_end i_tsc_cpu_end (.clk(clk), .rst_n(rst_n), .instr_valid(iv),
        .instr(instr), .instr_pc(pc), .rs_val(rs), .rt_val(rt),
        .instr_ready(ir), .lsu_idle(lsu_idle), .exc_valid(ev),
        .exc_kind(ek), .exc_pc(epc), .wb_valid(wv), .wb_reg(wreg),
        .wb_data(wd), .redirect_valid(rv), .redirect_pc(rpc),
        .mem_req(mreq), .mem_we(mwe), .mem_addr(ma), .mem_wdata(mwd),
        .mem_ack(mem_ack), .mem_rdata(MW), .cop(link.cpu_end));
    tsc_cop_end i_tsc_cop_end (.clk(clk), .rst_n(rst_n),
        .cop(link.cop_end), .cond_in(cin), .op_valid(ov), .op_unit(ou),
        .op_fun(fn));
    tsc_link_chk i_tsc_link_chk (.clk(clk), .rst_n(rst_n),
        .req_valid(link.req_valid), .req_kind(link.req_kind),
        .req_unit(link.req_unit), .req_idx(link.req_idx),
        .req_wdata(link.req_wdata), .rsp_valid(link.rsp_valid),
        .rsp_data(link.rsp_data));
    // Clock
    initial begin
        forever #20 clk = ~clk;
    end
    // Pulse counts, memory answer after three waits, watchdog
    always @(posedge clk) begin
        cyc <= cyc + 1;
        en <= en + ev;
        wn <= wn + wv;
        rn <= rn + rv;
        on <= on + ov;
        mc <= (mreq && !mem_ack) ? mc + 1 : 0;
        mem_ack <= mreq && !mem_ack && mc == 2;
        if (mreq) begin
            {ma_l, mwd_l, we_l} <= {ma, mwd, mwe};
        end
        if (cyc == 2000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ======================================================
    // Helpers
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic go(input logic [31:0] i, input logic [63:0] a, b);
        logic ok;
        #1 iv = 1;
        {instr, rs, rt} = {i, a, b};
        pc = pc + 64'h4;
        // Ready read between edges, where it is settled
        do begin
            ok = ir;
            @(posedge clk);
        end while (ok !== 1'b1);
    endtask : go
    task automatic stop(input int n);
        #1 iv = 0;
        repeat (n) @(posedge clk);
    endtask : stop
    function automatic logic [31:0] sp(input logic [5:0] f);
        return {OP_SPECIAL, 20'h0, f};
    endfunction : sp
    function automatic logic [31:0] ri(input logic [4:0] s, logic [15:0] m);
        return {OP_REG_IMM, 5'h0, s, m};
    endfunction : ri
    function automatic logic [31:0] cp(input logic [1:0] u, logic [4:0] s,
        logic [4:0] r, logic [4:0] d);
        return {OPG_COP, u, s, r, d, 11'h0};
    endfunction : cp
    // One exception case: pulse count, kind and address
    task automatic tc(input logic [31:0] i, input logic [63:0] a, b,
        input tsc_exc_t k);
        int n0;
        n0 = en;
        go(i, a, b);
        stop(2);
        chk(64'(en - n0), 64'(k != EXC_NONE));
        if (k != EXC_NONE) begin
            chk({62'h0, ek}, {62'h0, k});
            chk(epc, pc);
        end
    endtask : tc
    // ======================================================
    // Scenarios
    task automatic t_traps();
        tc(sp(FN_SYSCALL), 0, 0, EXC_SYSCALL);
        tc(sp(FN_BREAK), 0, 0, EXC_BREAK);
        tc(sp(FN_TRAP_GE_S), N, 1, EXC_NONE);
        tc(sp(FN_TRAP_GE_S), 1, 1, EXC_TRAP);
        tc(sp(FN_TRAP_LT_S), N, 1, EXC_TRAP);
        tc(sp(FN_TRAP_GE_U), N, 1, EXC_TRAP);
        tc(sp(FN_TRAP_LT_U), N, 1, EXC_NONE);
        tc(sp(FN_TRAP_EQ), 5, 5, EXC_TRAP);
        tc(sp(FN_TRAP_NE), 5, 5, EXC_NONE);
        tc(sp(FN_TRAP_NE), 5, 4, EXC_TRAP);
        tc(ri(RI_TRAP_GE_S, 16'h8000), 0, 0, EXC_TRAP);
        tc(ri(RI_TRAP_LT_S, 16'h8000), 0, 0, EXC_NONE);
        tc(ri(RI_TRAP_GE_U, 16'h8000), 0, 0, EXC_NONE);
        tc(ri(RI_TRAP_LT_U, 16'h8000), 0, 0, EXC_TRAP);
        tc(ri(RI_TRAP_EQ, 16'hffff), N, 0, EXC_TRAP);
        tc(ri(RI_TRAP_NE, 16'hffff), N, 0, EXC_NONE);
        tc(ri(RI_TRAP_NE, 16'h0006), 5, 0, EXC_TRAP);
    endtask : t_traps
    task automatic t_moves();
        go(cp(2'd1, CS_MT, 5'd0, 5'd3), 0, 64'h1234_5678);
        go(cp(2'd1, CS_MF, 5'd9, 5'd3), 0, 0);
        stop(4);
        chk(wd, 64'h1234_5678);
        go(cp(2'd3, CS_CT, 5'd0, 5'd31), 0, 64'h8000_0001);
        go(cp(2'd3, CS_CF, 5'd4, 5'd31), 0, 0);
        stop(4);
        chk(wd, 64'hffff_ffff_8000_0001);
        chk({59'h0, wreg}, 64'h4);
    endtask : t_moves
    task automatic t_mem();
        go({OPG_LWC, 2'd2, 5'd0, 5'd7, 16'hfffc}, 64'h1000, 0);
        stop(8);
        chk({ma_l[62:0], we_l}, {63'hffc, 1'b0});
        go({OPG_SWC, 2'd2, 5'd0, 5'd7, 16'h0010}, 64'h2000, 0);
        stop(10);
        chk({ma_l[62:0], we_l}, {63'h2010, 1'b1});
        chk({32'h0, mwd_l}, {32'h0, MW});
    endtask : t_mem
    task automatic t_op();
        int w0, o0;
        w0 = wn + en + rn;
        o0 = on;
        go({OPG_COP, 2'd3, 1'b1, 25'h0ab_cdef}, 0, 0);
        stop(3);
        chk({37'h0, ou, fn}, {37'h0, 2'd3, 25'h0ab_cdef});
        chk(64'(on - o0), 64'h1);
        chk(64'(wn + en + rn - w0), 0);
    endtask : t_op
    task automatic t_branch();
        logic [63:0] t;
        #1 cin = 4'h4;
        // Condition reaches the link one cycle late
        @(posedge clk);
        go({OPG_COP, 2'd2, CS_BC, 5'd1, 16'hfffe}, 0, 0);
        t = pc - 64'h4;
        go(sp(6'h00), 0, 0);
        stop(2);
        chk(rpc, t);
        go({OPG_COP, 2'd2, CS_BC, 5'd0, 16'h0010}, 0, 0);
        go(sp(6'h00), 0, 0);
        go({OPG_COP, 2'd1, CS_BC, 5'd0, 16'h0010}, 0, 0);
        t = pc + 64'h44;
        go(sp(6'h00), 0, 0);
        stop(2);
        chk(rpc, t);
        chk(64'(rn), 64'h2);
    endtask : t_branch
    task automatic t_sync();
        #1 lsu_idle = 0;
        @(posedge clk);
        go(sp(FN_SYNC), 0, 0);
        stop(4);
        chk({63'h0, ir}, 64'h0);
        #1 lsu_idle = 1;
        repeat (3) @(posedge clk);
        chk({63'h0, ir}, 64'h1);
    endtask : t_sync
    // ======================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        @(posedge clk);
        t_traps();
        t_moves();
        t_mem();
        t_op();
        t_branch();
        t_sync();
        give_verdict();
    end
endmodule : trap_sync_coproc_exec_tb
